// File: shared/agi_regs.svh
// Timing counts and the fixed stack pointer register number for the address interlock stall logic.
// Assumes the core numbers its eight integer registers with the stack pointer at 4.
`ifndef AGI_REGS_SVH
`define AGI_REGS_SVH
`define AGI_STALL_CYCLES 5'h01
`define MISALIGN_CYCLES  5'h03
`define PREFIX_CYCLES    5'h01
`define SP_REG_NUM       3'h4
`define CNT_RESET        5'h00
`define HIST_DEPTH       3
`endif

// File: shared/agi_pkg.sv
// Types shared by the address interlock stall logic.
// Assumes nothing beyond a SystemVerilog tool.
package agi_pkg;
    typedef enum logic [1:0] {
        SIZE_1 = 2'h0,
        SIZE_2 = 2'h1,
        SIZE_4 = 2'h2,
        SIZE_8 = 2'h3
    } access_size_e;
    typedef enum logic [1:0] {
        ST_CHECK = 2'b01,
        ST_WAIT  = 2'b10
    } stall_state_e;
    typedef logic [2:0] reg_num_t;
    typedef logic [4:0] cycle_count_t;
endpackage : agi_pkg

// File: verilog/address_generation_interlock.sv
// Decode-stage stall logic: address interlocks, misalignment and prefix clocks.
// Assumes decode holds its descriptor stable until dec_accept, and execute reports per slot.
`timescale 1ns/1ps
`include "agi_regs.svh"

module address_generation_interlock #(
    parameter int HIST_DEPTH = `HIST_DEPTH
) (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  clk_en,
    // Instruction at decode.
    input  wire logic                  dec_valid,
    input  wire logic                  dec_base_used,
    input  wire agi_pkg::reg_num_t     dec_base_reg,
    input  wire logic                  dec_index_used,
    input  wire agi_pkg::reg_num_t     dec_index_reg,
    input  wire logic                  dec_sp_implicit,
    input  wire logic                  dec_dest_used,
    input  wire agi_pkg::reg_num_t     dec_dest_reg,
    input  wire logic                  dec_sp_implicit_write,
    input  wire logic                  dec_mem,
    input  wire agi_pkg::access_size_e dec_size,
    input  wire logic [2:0]            dec_addr_low,
    input  wire logic [2:0]            dec_prefix_count,
    input  wire logic                  dec_escape,
    input  wire logic                  dec_near_jcc,
    // Execute-stage completion, one bit per history slot.
    input  wire logic [HIST_DEPTH-1:0] exec_done_mask,
    // Handshake towards decode.
    output logic                       dec_accept,
    output logic                       dec_hold,
    // Status.
    output logic                       interlock_reg,
    output logic                       misalign_reg,
    output agi_pkg::cycle_count_t      extra_cycles_reg,
    output logic [HIST_DEPTH-1:0]      pend_valid_reg
);

    // ==========================================================================
    // Helper functions

    // Sub-register writes stall like full writes
    // Register number only: a sub-register write is a write to the whole register.
    function automatic logic uses_reg(input logic b_used, input agi_pkg::reg_num_t b_reg,
                                      input logic i_used, input agi_pkg::reg_num_t i_reg,
                                      input logic sp_imp, input agi_pkg::reg_num_t dest);
        uses_reg = (b_used && b_reg == dest) || (i_used && i_reg == dest) ||
                   (sp_imp && dest == `SP_REG_NUM);
    endfunction : uses_reg

    function automatic logic is_misaligned(input agi_pkg::access_size_e size, input logic [2:0] addr);
        logic mis;
        mis = 1'b0;
        unique case (size)
            agi_pkg::SIZE_1: mis = 1'b0;
            agi_pkg::SIZE_2: mis = (addr[1:0] == 2'h3);
            agi_pkg::SIZE_4: mis = (addr[1:0] != 2'h0);
            agi_pkg::SIZE_8: mis = (addr != 3'h0);
        endcase
        is_misaligned = mis;
    endfunction : is_misaligned

    // ==========================================================================
    // Interlock detection

    agi_pkg::reg_num_t     pend_dest_reg [HIST_DEPTH];
    agi_pkg::stall_state_e state_reg;
    agi_pkg::cycle_count_t wait_cnt_reg;
    logic                  agi_hit;
    logic                  mis_now;
    logic                  record_dest;
    agi_pkg::cycle_count_t prefix_cycles;
    agi_pkg::cycle_count_t extra_now;

    always_comb begin
        agi_hit = 1'b0;
        for (int i = 0; i < HIST_DEPTH; i++) begin
            if (pend_valid_reg[i] && uses_reg(dec_base_used, dec_base_reg, dec_index_used, dec_index_reg,
                                              dec_sp_implicit, pend_dest_reg[i])) begin
                agi_hit = 1'b1;
            end
        end
    end

    assign record_dest = dec_dest_used && !(dec_sp_implicit_write && dec_dest_reg == `SP_REG_NUM);

    assign mis_now = dec_mem && is_misaligned(dec_size, dec_addr_low);

    assign prefix_cycles = agi_pkg::cycle_count_t'(dec_prefix_count) +
                           ((dec_escape && !dec_near_jcc) ? `PREFIX_CYCLES : `CNT_RESET);

    assign extra_now = (agi_hit ? `AGI_STALL_CYCLES : `CNT_RESET) + prefix_cycles +
                       (mis_now ? `MISALIGN_CYCLES : `CNT_RESET);

    // ==========================================================================
    // Hold sequencing

    always_comb begin
        dec_accept = 1'b0;
        if (dec_valid && clk_en) begin
            unique case (state_reg)
                agi_pkg::ST_CHECK: dec_accept = (extra_now == `CNT_RESET);
                agi_pkg::ST_WAIT:  dec_accept = (wait_cnt_reg == `CNT_RESET);
                default:           dec_accept = 1'b0;
            endcase
        end
    end

    assign dec_hold = dec_valid && !dec_accept;

    // The descriptor is costed once on arrival; the wait state only counts down, so the
    // penalty cannot be charged twice while decode holds the same instruction.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= agi_pkg::ST_CHECK;
            wait_cnt_reg <= `CNT_RESET;
        end else if (clk_en) begin
            unique case (state_reg)
                agi_pkg::ST_CHECK: begin
                    if (dec_valid && extra_now != `CNT_RESET) begin
                        state_reg    <= agi_pkg::ST_WAIT;
                        wait_cnt_reg <= extra_now - 5'h01;
                    end
                end
                agi_pkg::ST_WAIT: begin
                    if (wait_cnt_reg == `CNT_RESET) begin
                        state_reg <= agi_pkg::ST_CHECK;
                    end else begin
                        wait_cnt_reg <= wait_cnt_reg - 5'h01;
                    end
                end
                default: begin
                    state_reg    <= agi_pkg::ST_CHECK;
                    wait_cnt_reg <= `CNT_RESET;
                end
            endcase
        end
    end

    // ==========================================================================
    // In-flight history

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_valid_reg <= '0;
            for (int i = 0; i < HIST_DEPTH; i++) begin
                pend_dest_reg[i] <= 3'h0;
            end
        end else if (clk_en) begin
            pend_valid_reg[0] <= dec_accept && record_dest;
            pend_dest_reg[0]  <= dec_dest_reg;
            for (int i = 1; i < HIST_DEPTH; i++) begin
                pend_valid_reg[i] <= pend_valid_reg[i-1] && !exec_done_mask[i-1];
                pend_dest_reg[i]  <= pend_dest_reg[i-1];
            end
        end
    end

    // ==========================================================================
    // Status

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interlock_reg    <= 1'b0;
            misalign_reg     <= 1'b0;
            extra_cycles_reg <= `CNT_RESET;
        end else if (clk_en) begin
            interlock_reg <= dec_valid && state_reg == agi_pkg::ST_CHECK && agi_hit;
            if (dec_valid && state_reg == agi_pkg::ST_CHECK) begin
                misalign_reg     <= mis_now;
                extra_cycles_reg <= extra_now;
            end
        end
    end

    // ==========================================================================
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || !clk_en);

    logic fresh;
    assign fresh = dec_valid && state_reg == agi_pkg::ST_CHECK;

    sequence s_one_hold;
        !dec_accept ##1 dec_accept;
    endsequence

    sequence s_three_holds;
        !dec_accept [*3] ##1 dec_accept;
    endsequence

    property p_agi_stall_one;
        fresh && agi_hit && prefix_cycles == 5'h00 && !mis_now |-> s_one_hold;
    endproperty
    a_agi_stall_one: assert property (p_agi_stall_one) else $error("interlock stall is not one clock");

    property p_depth_three;
        pend_valid_reg[HIST_DEPTH-2] && !exec_done_mask[HIST_DEPTH-2] |=> pend_valid_reg[HIST_DEPTH-1];
    endproperty
    a_depth_three: assert property (p_depth_three) else $error("older writer dropped early");

    property p_pending_blocks;
        fresh && dec_base_used && pend_valid_reg[0] && pend_dest_reg[0] == dec_base_reg |-> !dec_accept;
    endproperty
    a_pending_blocks: assert property (p_pending_blocks) else $error("base used before execute done");

    property p_sp_explicit;
        fresh && dec_sp_implicit && pend_valid_reg[0] && pend_dest_reg[0] == `SP_REG_NUM |-> !dec_accept;
    endproperty
    a_sp_explicit: assert property (p_sp_explicit) else $error("push after SP write not stalled");

    property p_sp_implicit;
        dec_accept && dec_sp_implicit_write && dec_dest_reg == `SP_REG_NUM |=> !pend_valid_reg[0];
    endproperty
    a_sp_implicit: assert property (p_sp_implicit) else $error("implicit SP update recorded");

    property p_misalign_three;
        fresh && mis_now && !agi_hit && prefix_cycles == 5'h00 |-> s_three_holds;
    endproperty
    a_misalign_three: assert property (p_misalign_three) else $error("misalign penalty not three");

    property p_half_aligned;
        dec_mem && dec_size == agi_pkg::SIZE_2 && dec_addr_low[1:0] != 2'h3 |-> !mis_now;
    endproperty
    a_half_aligned: assert property (p_half_aligned) else $error("2-byte access wrongly misaligned");

    property p_dword_misaligned;
        fresh && dec_mem && dec_size == agi_pkg::SIZE_8 && dec_addr_low == 3'h4 && !agi_hit &&
        prefix_cycles == 5'h00 |=> misalign_reg;
    endproperty
    a_dword_misaligned: assert property (p_dword_misaligned) else $error("8-byte access not flagged");

    property p_prefix_clocks;
        fresh && !agi_hit && !mis_now && !dec_escape && dec_prefix_count == 3'h3 |-> s_three_holds;
    endproperty
    a_prefix_clocks: assert property (p_prefix_clocks) else $error("prefix clocks miscounted");

    property p_jcc_free;
        fresh && !agi_hit && !mis_now && dec_escape && dec_near_jcc && dec_prefix_count == 3'h0 |-> dec_accept;
    endproperty
    a_jcc_free: assert property (p_jcc_free) else $error("escaped jump charged");

    property p_escape_charged;
        fresh && !agi_hit && !mis_now && dec_escape && !dec_near_jcc && dec_prefix_count == 3'h0 |-> s_one_hold;
    endproperty
    a_escape_charged: assert property (p_escape_charged) else $error("escape opcode not charged");

    property p_older_advance;
        dec_hold && pend_valid_reg[0] && !exec_done_mask[0] |=> pend_valid_reg[1] && !pend_valid_reg[0];
    endproperty
    a_older_advance: assert property (p_older_advance) else $error("older entry held during stall");

    property p_half_crossing;
        dec_mem && dec_size == agi_pkg::SIZE_2 && dec_addr_low[1:0] == 2'h3 |-> mis_now;
    endproperty
    a_half_crossing: assert property (p_half_crossing) else $error("word-crossing 2-byte access not flagged");

    property p_quad_aligned;
        dec_mem && dec_size == agi_pkg::SIZE_4 && dec_addr_low[1:0] == 2'h0 |-> !mis_now;
    endproperty
    a_quad_aligned: assert property (p_quad_aligned) else $error("aligned 4-byte access flagged");

    property p_exec_clears;
        pend_valid_reg[0] && exec_done_mask[0] |=> !pend_valid_reg[1];
    endproperty
    a_exec_clears: assert property (p_exec_clears) else $error("finished writer still pending");

    property p_index_free;
        fresh && dec_index_used && !agi_hit && !mis_now && dec_prefix_count == 3'h0 && !dec_escape |-> dec_accept;
    endproperty
    a_index_free: assert property (p_index_free) else $error("indexed operand charged a clock");

endmodule : address_generation_interlock

// File: bench/tb.sv
// Self-checking bench for the address interlock stall logic.
// Assumes decode holds its descriptor until dec_accept and status registers settle a cycle after arrival.
`timescale 1ns/1ps

module tb;
    // ==========================================
    // Stimulus and observed signals
    logic                  clk;
    logic                  reset_n;
    logic                  clk_en;
    logic                  dec_valid;
    logic                  dec_base_used;
    agi_pkg::reg_num_t     dec_base_reg;
    logic                  dec_index_used;
    agi_pkg::reg_num_t     dec_index_reg;
    logic                  dec_sp_implicit;
    logic                  dec_dest_used;
    agi_pkg::reg_num_t     dec_dest_reg;
    logic                  dec_sp_implicit_write;
    logic                  dec_mem;
    agi_pkg::access_size_e dec_size;
    logic [2:0]            dec_addr_low;
    logic [2:0]            dec_prefix_count;
    logic                  dec_escape;
    logic                  dec_near_jcc;
    logic [2:0]            exec_done_mask;
    logic                  dec_accept;
    logic                  dec_hold;
    logic                  interlock_reg;
    logic                  misalign_reg;
    agi_pkg::cycle_count_t extra_cycles_reg;
    logic [2:0]            pend_valid_reg;
    int                    fails = 0;
    int                    n_checks = 0;
    int                    cycles = 0;

    address_generation_interlock #(.HIST_DEPTH(3)) dut_u (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .dec_valid(dec_valid),
        .dec_base_used(dec_base_used), .dec_base_reg(dec_base_reg), .dec_index_used(dec_index_used),
        .dec_index_reg(dec_index_reg), .dec_sp_implicit(dec_sp_implicit), .dec_dest_used(dec_dest_used),
        .dec_dest_reg(dec_dest_reg), .dec_sp_implicit_write(dec_sp_implicit_write), .dec_mem(dec_mem),
        .dec_size(dec_size), .dec_addr_low(dec_addr_low), .dec_prefix_count(dec_prefix_count),
        .dec_escape(dec_escape), .dec_near_jcc(dec_near_jcc), .exec_done_mask(exec_done_mask),
        .dec_accept(dec_accept), .dec_hold(dec_hold), .interlock_reg(interlock_reg),
        .misalign_reg(misalign_reg), .extra_cycles_reg(extra_cycles_reg), .pend_valid_reg(pend_valid_reg));

    // ==========================================
    // Clock, timeout and verdict
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    // The accept loop gives up by itself after 20 cycles; any other hang is cut short well above the roughly 180 cycles the run needs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            test_done();
        end
    end

    task automatic test_done;
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // ==========================================
    // Shared tasks
    task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic [3:0] r(input logic [2:0] n);
        return {1'h1, n};
    endfunction : r

    // Presents one instruction, counts stall cycles and judges the status it leaves behind.
    // Operand fields are {used, reg}; mm is {mem, size, addr}; pf is {near_jcc, escape, count}.
    task automatic issue(input logic [3:0] b, input logic [3:0] x, input logic [3:0] d, input logic [1:0] sp,
                         input logic [5:0] mm, input logic [4:0] pf, input logic [4:0] ek,
                         input logic em, input logic ea);
        int   k;
        logic agi;
        k = 0;
        agi = 1'h0;
        {dec_base_used, dec_base_reg} = b;
        {dec_index_used, dec_index_reg} = x;
        {dec_dest_used, dec_dest_reg} = d;
        {dec_sp_implicit, dec_sp_implicit_write} = sp;
        dec_mem = mm[5];
        dec_size = agi_pkg::access_size_e'(mm[4:3]);
        dec_addr_low = mm[2:0];
        {dec_near_jcc, dec_escape, dec_prefix_count} = pf;
        dec_valid = 1'h1;
        #1;
        while (dec_accept !== 1'h1 && k < 20) begin
            chk("dec_hold", 5'h01, {4'h0, dec_hold});
            @(negedge clk);
            k++;
            agi = agi | interlock_reg;
        end
        @(negedge clk);
        agi = agi | interlock_reg;
        chk("accept_wait", ek, 5'(k));
        chk("extra_cycles_reg", ek, extra_cycles_reg);
        chk("misalign_reg", {4'h0, em}, {4'h0, misalign_reg});
        chk("interlock_reg", {4'h0, ea}, {4'h0, agi});
    endtask : issue

    task automatic nop;
        issue(4'h0, 4'h0, 4'h0, 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
    endtask : nop

    // Three register-free instructions push every writer out of the history.
    task automatic flush;
        repeat (3) nop();
    endtask : flush

    function automatic logic mis_of(input int s, input int a);
        case (s)
            1: return (a % 4) == 3;
            2: return (a % 4) != 0;
            3: return a != 0;
            default: return 1'h0;
        endcase
    endfunction : mis_of

    // ==========================================
    // Scenarios
    task automatic t_adjacent;
        issue(4'h0, 4'h0, r(3'h2), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        issue(r(3'h2), 4'h0, 4'h0, 2'h0, 6'h30, 5'h00, 5'h01, 1'h0, 1'h1);
        issue(4'h0, 4'h0, r(3'h5), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        issue(r(3'h3), r(3'h5), 4'h0, 2'h0, 6'h30, 5'h00, 5'h01, 1'h0, 1'h1);
        issue(4'h0, 4'h0, r(3'h0), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        issue(r(3'h6), r(3'h3), r(3'h0), 2'h0, 6'h30, 5'h00, 5'h00, 1'h0, 1'h0);
        flush();
    endtask : t_adjacent

    task automatic t_three_back;
        issue(4'h0, 4'h0, r(3'h6), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        nop();
        nop();
        chk("pend_valid_reg", 5'h04, {2'h0, pend_valid_reg});
        issue(r(3'h6), 4'h0, 4'h0, 2'h0, 6'h30, 5'h00, 5'h01, 1'h0, 1'h1);
        flush();
        issue(4'h0, 4'h0, r(3'h1), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        flush();
        issue(r(3'h1), 4'h0, 4'h0, 2'h0, 6'h30, 5'h00, 5'h00, 1'h0, 1'h0);
    endtask : t_three_back

    task automatic t_exec_done;
        issue(4'h0, 4'h0, r(3'h7), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        exec_done_mask = 3'h1;
        nop();
        exec_done_mask = 3'h0;
        chk("pend_valid_reg", 5'h00, {2'h0, pend_valid_reg});
        issue(r(3'h7), 4'h0, 4'h0, 2'h0, 6'h30, 5'h00, 5'h00, 1'h0, 1'h0);
        flush();
    endtask : t_exec_done

    task automatic t_stack;
        issue(4'h0, 4'h0, r(3'h4), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        issue(4'h0, 4'h0, r(3'h4), 2'h3, 6'h30, 5'h00, 5'h01, 1'h0, 1'h1);
        flush();
        issue(4'h0, 4'h0, r(3'h4), 2'h3, 6'h30, 5'h00, 5'h00, 1'h0, 1'h0);
        issue(r(3'h4), 4'h0, r(3'h3), 2'h0, 6'h30, 5'h00, 5'h00, 1'h0, 1'h0);
        issue(4'h0, 4'h0, r(3'h4), 2'h3, 6'h30, 5'h00, 5'h00, 1'h0, 1'h0);
        flush();
    endtask : t_stack

    task automatic t_align;
        logic m;
        for (int s = 0; s < 4; s++) begin
            for (int a = 0; a < 8; a++) begin
                m = mis_of(s, a);
                issue(4'h0, 4'h0, 4'h0, 2'h0, {1'h1, 2'(s), 3'(a)}, 5'h00,
                      m ? 5'h03 : 5'h00, m, 1'h0);
            end
        end
        issue(4'h0, 4'h0, 4'h0, 2'h0, 6'h11, 5'h00, 5'h00, 1'h0, 1'h0);
    endtask : t_align

    task automatic t_prefix;
        for (int p = 0; p < 4; p++) begin
            for (int e = 0; e < 2; e++) begin
                for (int j = 0; j <= e; j++) begin
                    issue(4'h0, 4'h0, 4'h0, 2'h0, 6'h00, {1'(j), 1'(e), 3'(p)},
                          5'(p + (e & ~j)), 1'h0, 1'h0);
                end
            end
        end
        issue(4'h0, 4'h0, 4'h0, 2'h0, 6'h00, 5'h07, 5'h07, 1'h0, 1'h0);
        issue(4'h0, 4'h0, r(3'h1), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        issue(r(3'h1), 4'h0, 4'h0, 2'h0, 6'h31, 5'h02, 5'h06, 1'h1, 1'h1);
    endtask : t_prefix

    // Three frozen cycles would otherwise age the writer out, so the stall proves the history held.
    task automatic t_freeze;
        issue(4'h0, 4'h0, r(3'h2), 2'h0, 6'h00, 5'h00, 5'h00, 1'h0, 1'h0);
        clk_en = 1'h0;
        repeat (3) begin
            @(negedge clk);
            chk("frozen_accept", 5'h00, {4'h0, dec_accept});
        end
        chk("pend_valid_reg", 5'h01, {2'h0, pend_valid_reg});
        clk_en = 1'h1;
        issue(r(3'h2), 4'h0, 4'h0, 2'h0, 6'h30, 5'h00, 5'h01, 1'h0, 1'h1);
        flush();
    endtask : t_freeze

    // ==========================================
    // Main sequence
    initial begin
        reset_n = 1'h0;
        clk_en = 1'h1;
        exec_done_mask = 3'h0;
        dec_valid = 1'h0;
        {dec_base_used, dec_base_reg, dec_index_used, dec_index_reg} = 8'h00;
        {dec_dest_used, dec_dest_reg, dec_sp_implicit, dec_sp_implicit_write} = 6'h00;
        {dec_mem, dec_addr_low, dec_prefix_count, dec_escape, dec_near_jcc} = 9'h000;
        dec_size = agi_pkg::SIZE_1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset_n = 1'h1;
        t_adjacent();
        t_three_back();
        t_exec_done();
        t_stack();
        t_align();
        t_prefix();
        t_freeze();
        dec_valid = 1'h0;
        test_done();
    end
endmodule : tb
